// File: msc_pkg.sv
// Function
// - A single-bit set, clear, invert or store does a full byte read, changes one bit, and writes the whole byte back, so stale values can land in write-only bits.
// - Mode register bit 7 is a reserved read/write bit that resets to 1, and software writes only 1 to it.
// - Mode register bits 6 to 3 always read 0 and ignore writes.
// - Mode register bits 2 to 0 are read-only and show the three strap levels in order, bit 2 for the highest strap.
// - The strap levels are latched into the mode level bits when the mode register is read, and a reset clears the latch.
// - System control bit 7 resets to 0 for plain multiply-accumulate and selects saturation when 1.
// - System control bits 5:4 pick the interrupt controller mode, reset to 00, 00 is mode 0, 10 is mode 2, and 01 and 11 are not written.
// - System control bit 3 resets to 0 for a falling-edge non-maskable request and selects the rising edge when 1.
// - System control bit 0 enables on-chip RAM when 1 and returns to 1 at reset.
// - System control bits 6, 2 and 1 always read 0 and ignore writes.
package msc_pkg;

	localparam int ADDR_W = 8;

	// byte addresses of the register words
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SYSC = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_BITOP = 8'h08;

	// reset values
	localparam logic MODE_RSV7_RST = 1'b1;
	localparam logic [2:0] MODE_LATCH_RST = 3'h0;
	localparam logic [7:0] SYSC_RST = 8'h01;
	localparam logic [7:0] BITOP_RST = 8'h00;

	// field positions
	localparam int MODE_RSV7_BIT = 7;
	localparam int SYSC_MAC_SATURATE_SELECT_BIT = 7;
	localparam int SYSC_INTM_HI_BIT = 5;
	localparam int SYSC_INTM_LO_BIT = 4;
	localparam int SYSC_NMIEDGE_BIT = 3;
	localparam int SYSC_ONCHIP_RAM_ENABLE_BIT = 0;
	localparam int BITOP_BUSY_BIT = 8;

	// writable bits of each register
	localparam logic [7:0] MODE_WMASK = 8'h80;
	localparam logic [7:0] SYSC_WMASK = 8'h89;

	// bit operation command byte: [2:0] bit, [5:3] op, [6] target, [7] store value
	localparam int BITOP_OP_LSB = 3;
	localparam int BITOP_TGT_BIT = 6;
	localparam int BITOP_VAL_BIT = 7;
	localparam logic [2:0] OP_SET = 3'h0;
	localparam logic [2:0] OP_CLR = 3'h1;
	localparam logic [2:0] OP_INV = 3'h2;
	localparam logic [2:0] OP_STORE = 3'h3;
	localparam logic [2:0] OP_ISTORE = 3'h4;

	// interrupt controller mode codes
	localparam logic [1:0] INTM_MODE0 = 2'h0;
	localparam logic [1:0] INTM_MODE2 = 2'h2;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BOP_IDLE, BOP_READ, BOP_WRITE} msc_bop_t;
	typedef enum logic [1:0] {RD_IDLE, RD_ISSUE, RD_WAIT, RD_RESP} msc_rd_t;

endpackage : msc_pkg

// File: msc_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the bus front end and the byte register bank
interface msc_reg_if;
	logic wr_en;
	logic rd_en;
	logic sel_sysc;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic bop_en;
	logic [7:0] bop_cmd;
	logic busy;
	logic [2:0] strap;
	logic [7:0] sysc_q;

	modport host (output wr_en, output rd_en, output sel_sysc, output wbyte, output bop_en,
		output bop_cmd, output strap, input rbyte, input busy, input sysc_q);
	modport bank (input wr_en, input rd_en, input sel_sysc, input wbyte, input bop_en,
		input bop_cmd, input strap, output rbyte, output busy, output sysc_q);
endinterface : msc_reg_if
`default_nettype wire

// File: msc_bank.sv
`timescale 1ns/1ps
`default_nettype none
module msc_bank
	import msc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	msc_reg_if.bank bus
);

	typedef struct packed {
		logic rsv7;
		logic [2:0] latch;
		logic [7:0] sysc;
		logic [7:0] rbyte;
		msc_bop_t bstate;
		logic [7:0] cmd;
		logic [7:0] tmp;
	} msc_bank_st_t;

	msc_bank_st_t q_r;
	msc_bank_st_t q_nxt;
	logic [7:0] bop_res;

	// merge a written byte into the system control byte
	function automatic logic [7:0] sysc_merge(input logic [7:0] old, input logic [7:0] b);
		logic [7:0] r;
		r = (old & ~SYSC_WMASK) | (b & SYSC_WMASK);
		// prohibited codes leave the previous mode in place
		if (b[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT] == INTM_MODE0 ||
			b[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT] == INTM_MODE2)
			r[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT] = b[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT];
		else
			r[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT] = old[SYSC_INTM_HI_BIT:SYSC_INTM_LO_BIT];
		return r;
	endfunction : sysc_merge

	// apply one bit operation to a byte
	function automatic logic [7:0] bit_apply(input logic [7:0] b, input logic [7:0] c);
		logic [7:0] r;
		logic [2:0] n;
		r = b;
		n = c[2:0];
		case (c[BITOP_OP_LSB+2:BITOP_OP_LSB])
			OP_SET: r[n] = 1'b1;
			OP_CLR: r[n] = 1'b0;
			OP_INV: r[n] = ~b[n];
			OP_STORE: r[n] = c[BITOP_VAL_BIT];
			OP_ISTORE: r[n] = ~c[BITOP_VAL_BIT];
			default: r = b;
		endcase
		return r;
	endfunction : bit_apply

	// result of the pending bit operation on the byte read back
	assign bop_res = bit_apply(q_r.tmp, q_r.cmd);

	// read, bit operation and write all fold into one next state
	always_comb
	begin
		q_nxt = q_r;
		if (bus.rd_en)
		begin
			if (bus.sel_sysc)
				q_nxt.rbyte = q_r.sysc;
			else
			begin
				q_nxt.latch = bus.strap;
				q_nxt.rbyte = {q_r.rsv7, 4'h0, bus.strap};
			end
		end
		case (q_r.bstate)
			BOP_IDLE:
			begin
				if (bus.bop_en)
				begin
					q_nxt.cmd = bus.bop_cmd;
					q_nxt.bstate = BOP_READ;
				end
			end
			BOP_READ:
			begin
				// full byte read first; a mode read latches the straps as usual
				if (q_r.cmd[BITOP_TGT_BIT])
					q_nxt.tmp = q_r.sysc;
				else
				begin
					q_nxt.latch = bus.strap;
					q_nxt.tmp = {q_r.rsv7, 4'h0, bus.strap};
				end
				q_nxt.bstate = BOP_WRITE;
			end
			BOP_WRITE:
			begin
				// whole byte goes back through the normal write masks
				if (q_r.cmd[BITOP_TGT_BIT])
					q_nxt.sysc = sysc_merge(q_r.sysc, bop_res);
				else
					q_nxt.rsv7 = bop_res[MODE_RSV7_BIT];
				q_nxt.bstate = BOP_IDLE;
			end
			default: q_nxt.bstate = BOP_IDLE;
		endcase
		if (bus.wr_en)
		begin
			if (bus.sel_sysc)
				q_nxt.sysc = sysc_merge(q_r.sysc, bus.wbyte);
			else
				q_nxt.rsv7 = bus.wbyte[MODE_RSV7_BIT];
		end
	end

	// reset drops the strap latch and restores the control byte
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q_r.rsv7 <= MODE_RSV7_RST;
			q_r.latch <= MODE_LATCH_RST;
			q_r.sysc <= SYSC_RST;
			q_r.rbyte <= 8'h00;
			q_r.bstate <= BOP_IDLE;
			q_r.cmd <= BITOP_RST;
			q_r.tmp <= 8'h00;
		end
		else
			q_r <= q_nxt;
	end

	assign bus.rbyte = q_r.rbyte;
	assign bus.busy = (q_r.bstate != BOP_IDLE);
	assign bus.sysc_q = q_r.sysc;

endmodule : msc_bank
`default_nettype wire

// File: msc_top.sv
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module msc_top
	import msc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// board straps and interrupt pin
	input wire logic mode_strap_pin_2,
	input wire logic mode_strap_pin_1,
	input wire logic mode_strap_pin_0,
	input wire logic nmi_pin,
	// control outputs
	output logic mac_saturate_select,
	output logic intc_mode_select_hi,
	output logic intc_mode_select_lo,
	output logic nonmaskable_edge_select,
	output logic onchip_ram_enable,
	output logic nmi_request
);

	typedef struct packed {
		logic [2:0] strap_m;
		logic [2:0] strap_s;
		logic nmi_m;
		logic nmi_s;
		logic nmi_d;
		logic nmi_req;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [7:0] w_byte;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		msc_rd_t rstate;
		logic [ADDR_W-1:0] ar_addr;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] cmd_last;
	} msc_top_st_t;

	msc_top_st_t q_r;
	msc_top_st_t q_nxt;

	msc_reg_if regs ();

	logic w_go;
	logic w_is_mode;
	logic w_is_sysc;
	logic w_is_bop;
	logic r_is_mode;
	logic r_is_sysc;
	logic r_is_bop;

	// protection bits carry no meaning for this block
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

	// word decode; low two address bits are ignored as the bus allows
	assign w_is_mode = (q_r.aw_addr[ADDR_W-1:2] == OFF_MODE[ADDR_W-1:2]);
	assign w_is_sysc = (q_r.aw_addr[ADDR_W-1:2] == OFF_SYSC[ADDR_W-1:2]);
	assign w_is_bop = (q_r.aw_addr[ADDR_W-1:2] == OFF_BITOP[ADDR_W-1:2]);
	assign r_is_mode = (q_r.ar_addr[ADDR_W-1:2] == OFF_MODE[ADDR_W-1:2]);
	assign r_is_sysc = (q_r.ar_addr[ADDR_W-1:2] == OFF_SYSC[ADDR_W-1:2]);
	assign r_is_bop = (q_r.ar_addr[ADDR_W-1:2] == OFF_BITOP[ADDR_W-1:2]);

	// a write completes once address and data are both held and no bit
	// operation is in flight; waiting here keeps byte writes atomic;
	// it also yields to a read issue, which owns the shared select line
	assign w_go = q_r.aw_full && q_r.w_full && !q_r.bvalid && !regs.busy &&
		(q_r.rstate != RD_ISSUE);

	// requests into the register bank; writes and bit operations gated by the byte lane that holds the data
	assign regs.wr_en = w_go && q_r.w_lane0 && (w_is_mode || w_is_sysc);
	assign regs.bop_en = w_go && q_r.w_lane0 && w_is_bop;
	assign regs.sel_sysc = (q_r.rstate == RD_ISSUE) ? r_is_sysc : w_is_sysc;
	assign regs.wbyte = q_r.w_byte;
	assign regs.bop_cmd = q_r.w_byte;
	assign regs.rd_en = (q_r.rstate == RD_ISSUE) && !regs.busy && (r_is_mode || r_is_sysc);
	assign regs.strap = q_r.strap_s;

	msc_bank u_bank (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.bus(regs.bank)
	);

	// all bus, synchroniser and edge logic in one next-state process
	always_comb
	begin
		q_nxt = q_r;
		// two-stage synchronisers; the first stage feeds only the second
		q_nxt.strap_m = {mode_strap_pin_2, mode_strap_pin_1, mode_strap_pin_0};
		q_nxt.strap_s = q_r.strap_m;
		q_nxt.nmi_m = nmi_pin;
		q_nxt.nmi_s = q_r.nmi_m;
		q_nxt.nmi_d = q_r.nmi_s;
		// edge selection follows the live control bit, one pulse per edge
		if (regs.sysc_q[SYSC_NMIEDGE_BIT])
			q_nxt.nmi_req = q_r.nmi_s && !q_r.nmi_d;
		else
			q_nxt.nmi_req = !q_r.nmi_s && q_r.nmi_d;

		// write address and data are taken independently, in either order
		if (s_axi_awvalid && q_r.awready)
		begin
			q_nxt.aw_full = 1'b1;
			q_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q_r.wready)
		begin
			q_nxt.w_full = 1'b1;
			q_nxt.w_byte = s_axi_wdata[7:0];
			q_nxt.w_lane0 = s_axi_wstrb[0];
		end
		if (w_go)
		begin
			q_nxt.aw_full = 1'b0;
			q_nxt.w_full = 1'b0;
			q_nxt.bvalid = 1'b1;
			if (w_is_mode || w_is_sysc || w_is_bop)
				q_nxt.bresp = RESP_OKAY;
			else
				q_nxt.bresp = RESP_SLVERR;
			if (w_is_bop && q_r.w_lane0)
				q_nxt.cmd_last = q_r.w_byte;
		end
		if (q_r.bvalid && s_axi_bready)
			q_nxt.bvalid = 1'b0;
		q_nxt.awready = !q_nxt.aw_full;
		q_nxt.wready = !q_nxt.w_full;

		// read channel walks a small sequence so data always leaves a flop
		case (q_r.rstate)
			RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					q_nxt.ar_addr = s_axi_araddr;
					q_nxt.arready = 1'b0;
					q_nxt.rstate = RD_ISSUE;
				end
			end
			RD_ISSUE:
			begin
				// hold off while a bit operation owns the bank
				if (!regs.busy)
				begin
					if (r_is_mode || r_is_sysc)
						q_nxt.rstate = RD_WAIT;
					else
					begin
						q_nxt.rvalid = 1'b1;
						q_nxt.rstate = RD_RESP;
						if (r_is_bop)
						begin
							q_nxt.rdata = {23'h000000, 1'b0, q_r.cmd_last};
							q_nxt.rresp = RESP_OKAY;
						end
						else
						begin
							q_nxt.rdata = 32'h00000000;
							q_nxt.rresp = RESP_SLVERR;
						end
					end
				end
			end
			RD_WAIT:
			begin
				// upper bits of both byte registers read as zero
				q_nxt.rdata = {24'h000000, regs.rbyte};
				q_nxt.rresp = RESP_OKAY;
				q_nxt.rvalid = 1'b1;
				q_nxt.rstate = RD_RESP;
			end
			RD_RESP:
			begin
				if (s_axi_rready)
				begin
					q_nxt.rvalid = 1'b0;
					q_nxt.arready = 1'b1;
					q_nxt.rstate = RD_IDLE;
				end
			end
			default:
			begin
				q_nxt.rvalid = 1'b0;
				q_nxt.arready = 1'b1;
				q_nxt.rstate = RD_IDLE;
			end
		endcase
		// busy flag of a command read is sampled live at issue time
		if (q_r.rstate == RD_ISSUE && r_is_bop)
			q_nxt.rdata[BITOP_BUSY_BIT] = regs.busy;
	end

	// constants only under reset; straps are caught later by the clocked path
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			q_r.strap_m <= 3'h0;
			q_r.strap_s <= 3'h0;
			q_r.nmi_m <= 1'b0;
			q_r.nmi_s <= 1'b0;
			q_r.nmi_d <= 1'b0;
			q_r.nmi_req <= 1'b0;
			q_r.aw_full <= 1'b0;
			q_r.aw_addr <= '0;
			q_r.w_full <= 1'b0;
			q_r.w_byte <= 8'h00;
			q_r.w_lane0 <= 1'b0;
			q_r.awready <= 1'b1;
			q_r.wready <= 1'b1;
			q_r.bvalid <= 1'b0;
			q_r.bresp <= RESP_OKAY;
			q_r.rstate <= RD_IDLE;
			q_r.ar_addr <= '0;
			q_r.arready <= 1'b1;
			q_r.rvalid <= 1'b0;
			q_r.rdata <= 32'h00000000;
			q_r.rresp <= RESP_OKAY;
			q_r.cmd_last <= BITOP_RST;
		end
		else
			q_r <= q_nxt;
	end

	// bus outputs straight from the state flops
	assign s_axi_awready = q_r.awready;
	assign s_axi_wready = q_r.wready;
	assign s_axi_bvalid = q_r.bvalid;
	assign s_axi_bresp = q_r.bresp;
	assign s_axi_arready = q_r.arready;
	assign s_axi_rvalid = q_r.rvalid;
	assign s_axi_rdata = q_r.rdata;
	assign s_axi_rresp = q_r.rresp;

	// control outputs come from the bank's system control flops, and the request from the nmi_req flop
	assign mac_saturate_select = regs.sysc_q[SYSC_MAC_SATURATE_SELECT_BIT];
	assign intc_mode_select_hi = regs.sysc_q[SYSC_INTM_HI_BIT];
	assign intc_mode_select_lo = regs.sysc_q[SYSC_INTM_LO_BIT];
	assign nonmaskable_edge_select = regs.sysc_q[SYSC_NMIEDGE_BIT];
	assign onchip_ram_enable = regs.sysc_q[SYSC_ONCHIP_RAM_ENABLE_BIT];
	assign nmi_request = q_r.nmi_req;

endmodule : msc_top
`default_nettype wire

// File: msc_props.sv
`timescale 1ns/1ps
`default_nettype none
module msc_props
	import msc_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic mode_strap_pin_2,
	input wire logic mode_strap_pin_1,
	input wire logic mode_strap_pin_0,
	input wire logic nmi_pin,
	input wire logic mac_saturate_select,
	input wire logic intc_mode_select_hi,
	input wire logic intc_mode_select_lo,
	input wire logic nonmaskable_edge_select,
	input wire logic onchip_ram_enable,
	input wire logic nmi_request
);
	logic [ADDR_W-1:0] ar_r;
	logic [2:0] since_w_r;
	logic [4:0] cfg;
	assign cfg = {mac_saturate_select, intc_mode_select_hi, intc_mode_select_lo,
		nonmaskable_edge_select, onchip_ram_enable};
	// remember the read address and how long ago a data beat was taken
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ar_r <= 8'h00;
			since_w_r <= 3'h7;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
				ar_r <= s_axi_araddr;
			if (s_axi_wvalid && s_axi_wready)
				since_w_r <= 3'h0;
			else if (since_w_r != 3'h7)
				since_w_r <= since_w_r + 3'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// the pin edges that may raise a request, per edge select
	sequence s_fall;
		!nonmaskable_edge_select && $fell(nmi_pin);
	endsequence
	sequence s_rise;
		nonmaskable_edge_select && $rose(nmi_pin);
	endsequence
	chk_reset_values: assert property (@(posedge mclk) disable iff (1'b0)
		sys_rst |-> onchip_ram_enable && cfg[4:1] == 4'h0)
		else $error("control outputs wrong during reset");
	chk_cfg_cause: assert property (!$stable(cfg) |-> since_w_r <= 3'h6)
		else $error("control output moved without a write");
	chk_sysc_mirror: assert property (s_axi_rvalid && ar_r == OFF_SYSC |->
		s_axi_rdata == {24'h0, cfg[4], 1'b0, cfg[3:1], 2'h0, cfg[0]})
		else $error("system control read disagrees with outputs");
	chk_mode_bits: assert property (s_axi_rvalid && ar_r == OFF_MODE |->
		{s_axi_rdata[31:8], s_axi_rdata[6:0]} ==
		{28'h0, mode_strap_pin_2, mode_strap_pin_1, mode_strap_pin_0})
		else $error("mode read bits wrong");
	chk_intm_legal: assert property (!intc_mode_select_lo)
		else $error("prohibited interrupt mode code held");
	chk_nmi_fall: assert property (s_fall |-> ##[1:5] nmi_request)
		else $error("no request after falling edge");
	chk_nmi_rise: assert property (s_rise |-> ##[1:5] nmi_request)
		else $error("no request after rising edge");
	chk_nmi_quiet: assert property ($stable(nmi_pin) [*6] |=> !nmi_request)
		else $error("request without a pin edge");
endmodule : msc_props
bind msc_top msc_props u_msc_props (.mclk, .sys_rst, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_wvalid, .s_axi_wready,
	.mode_strap_pin_2, .mode_strap_pin_1, .mode_strap_pin_0, .nmi_pin,
	.mac_saturate_select, .intc_mode_select_hi, .intc_mode_select_lo,
	.nonmaskable_edge_select, .onchip_ram_enable, .nmi_request);
`default_nettype wire

// File: msc_board.sv
`timescale 1ns/1ps
`default_nettype none
module msc_board
(
	input wire logic nmi_lvl,
	output logic mode_strap_pin_2,
	output logic mode_strap_pin_1,
	output logic mode_strap_pin_0,
	output logic nmi_pin
);
	// straps fixed high for the one usable mode and never moved while running
	assign {mode_strap_pin_2, mode_strap_pin_1, mode_strap_pin_0} = 3'h7;
	// interrupt pin simply follows the level the bench asks for
	assign nmi_pin = nmi_lvl;
endmodule : msc_board
`default_nettype wire

// File: mode_and_system_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module mode_and_system_control_test
	import msc_pkg::*;
;
	logic mclk, sys_rst, nmi_lvl, nmi_pin, p2, p1, p0;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, nmi_request;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, failures, n_tests, n_nmi;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	wire [4:0] cfg;
	logic [3:0] s_axi_wstrb;
	logic [7:0] bc [10] = '{8'h40, 8'h4d, 8'h57, 8'hdb, 8'h4b, 8'he0, 8'h46, 8'h40, 8'h0a, 8'h07};
	logic [7:0] be [10] = '{8'h21, 8'h01, 8'h81, 8'h89, 8'h81, 8'h80, 8'h80, 8'h81, 8'h87, 8'h87};
	msc_top u_msc_top (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
		.mode_strap_pin_2(p2), .mode_strap_pin_1(p1), .mode_strap_pin_0(p0),
		.nmi_pin(nmi_pin), .mac_saturate_select(cfg[4]), .intc_mode_select_hi(cfg[3]),
		.intc_mode_select_lo(cfg[2]), .nonmaskable_edge_select(cfg[1]),
		.onchip_ram_enable(cfg[0]), .nmi_request(nmi_request));
	msc_board u_msc_board (.nmi_lvl(nmi_lvl), .mode_strap_pin_2(p2),
		.mode_strap_pin_1(p1), .mode_strap_pin_0(p0), .nmi_pin(nmi_pin));
	// free-running clock, 40 ns period
	always #20 mclk = ~mclk;
	// count request pulses for the edge tests
	always @(posedge mclk)
		if (nmi_request === 1'b1)
			n_nmi <= n_nmi + 32'h1;
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_tests = n_tests + 32'h1;
		if (g !== e)
		begin
			failures = failures + 32'h1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge mclk);
			ad = ad | (s_axi_awready === 1'b1);
			wd = wd | (s_axi_wready === 1'b1);
			if (ad)
				s_axi_awvalid <= 1'b0;
			if (wd)
				s_axi_wvalid <= 1'b0;
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		cmp({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		cmp({30'h0, s_axi_rresp}, {30'h0, er});
		if (er === RESP_OKAY)
			cmp(s_axi_rdata, e);
	endtask : rd
	task automatic reset_dut();
		sys_rst <= 1'b1;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
	endtask : reset_dut
	task automatic nmi_step(input logic lvl, input logic [31:0] e);
		nmi_lvl <= lvl;
		repeat (10) @(posedge mclk);
		cmp(n_nmi, e);
	endtask : nmi_step
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 32'h0 && n_tests != 32'h0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	// main sequence of register traffic and pin activity
	initial
	begin
		{mclk, sys_rst, nmi_lvl, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'h10;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h1;
		{failures, n_tests, n_nmi} = 96'h0;
		reset_dut();
		rd(OFF_MODE, 32'h87, RESP_OKAY);
		rd(OFF_SYSC, 32'h01, RESP_OKAY);
		wr(OFF_MODE, 8'hff, RESP_OKAY);
		rd(OFF_MODE, 32'h87, RESP_OKAY);
		wr(OFF_MODE, 8'hf8, RESP_OKAY);
		rd(OFF_MODE, 32'h87, RESP_OKAY);
		wr(OFF_SYSC, 8'hef, RESP_OKAY);
		rd(OFF_SYSC, 32'ha9, RESP_OKAY);
		cmp({27'h0, cfg}, 32'h1b);
		wr(OFF_SYSC, 8'h00, RESP_OKAY);
		rd(OFF_SYSC, 32'h00, RESP_OKAY);
		wr(OFF_SYSC, 8'h20, RESP_OKAY);
		rd(OFF_SYSC, 32'h20, RESP_OKAY);
		// byte read-modify-write bit operations on both registers
		for (int i = 0; i < 10; i++)
		begin
			wr(OFF_BITOP, bc[i], RESP_OKAY);
			rd(bc[i][6] ? OFF_SYSC : OFF_MODE, {24'h0, be[i]}, RESP_OKAY);
		end
		rd(OFF_BITOP, 32'h07, RESP_OKAY);
		rd(8'h0c, 32'h0, RESP_SLVERR);
		wr(8'h0c, 8'h00, RESP_SLVERR);
		nmi_step(1'b1, 32'h0);
		nmi_step(1'b0, 32'h1);
		wr(OFF_SYSC, 8'h89, RESP_OKAY);
		nmi_step(1'b1, 32'h2);
		nmi_step(1'b0, 32'h2);
		// a write with its byte lane off must leave the control byte alone
		s_axi_wstrb <= 4'h0;
		wr(OFF_SYSC, 8'h00, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(OFF_SYSC, 32'h89, RESP_OKAY);
		// disturb the control byte, then reset again in mid-run
		wr(OFF_MODE, 8'h80, RESP_OKAY);
		wr(OFF_SYSC, 8'h20, RESP_OKAY);
		reset_dut();
		rd(OFF_MODE, 32'h87, RESP_OKAY);
		rd(OFF_SYSC, 32'h01, RESP_OKAY);
		end_of_test();
	end
	// watchdog in case a handshake never completes
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures = failures + 32'h1;
		end_of_test();
	end
endmodule : mode_and_system_control_test
`default_nettype wire
